/* hdl/uart_bank0_host_registers.v */
// How it works
// - Reset leaves legacy mode with fifos off until software selects otherwise.
// - Eight byte registers decoded at offsets 00h to 07h.
// - Data port read returns holding register or oldest receive fifo byte.
// - Data port write loads holding register or pushes into transmit fifo.
// - Enable bits 4 to 7 writable only extended; read zero otherwise.
// - Legacy enable bit 0 gates receive level and timeout, codes 0100/1100.
// - Legacy enable bit 1 gates transmit low level, code 0010.
// - Enable bit 2 gates line status interrupts, code 0110.
// - Enable bit 3 gates modem status interrupts, code 0000.
// - Extended enable bit 0 gates receive threshold or timeout interrupt.
// - Extended enable bit 1 gates transmit below threshold or holding empty.
// - Extended enable bit 5 gates transmitter and fifo both empty.
// - Offset 02h reads event id, writes fifo control.
// - Legacy mode ranks four levels, reports only the highest pending.
// - Legacy event id bit 0 is 0 when pending, 1 when idle.
// - Legacy event id bits 2,1 encode highest pending source, reset 00.
// - Legacy event id bit 3 set only for fifo timeout with fifos on.
// - Legacy event id bits 7,6 mirror fifo enable, reset 0.
// - Priority line, receive, transmit, modem; line clears on status read.
// - Transmit low clears on event id read while highest, or data write.
`timescale 1ns/100ps
`include "uart_bank0_defs.vh"

module uart_bank0_host_registers #(
	parameter LEVEL_W = 5
) (
	input wire core_clk_in,
	input wire sys_rst_in,
	input wire [2:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	input wire extended_select_in,
	input wire [7:0] rx_data_in,
	input wire [LEVEL_W-1:0] rx_level_in,
	input wire rx_timeout_in,
	output reg rx_pop_out,
	output reg rx_soft_reset_out,
	output reg [7:0] tx_data_out,
	output reg tx_push_out,
	input wire [LEVEL_W-1:0] tx_level_in,
	input wire tx_idle_in,
	output reg tx_soft_reset_out,
	input wire [7:0] line_status_in,
	input wire line_error_in,
	input wire [7:0] modem_status_in,
	input wire modem_change_in,
	output reg [7:0] line_ctrl_out,
	output reg [7:0] modem_control_out,
	output reg fifos_on_out,
	output reg irq_out
);

	function [LEVEL_W-1:0] rx_thr;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: rx_thr = `RX_THR_0;
				2'h1: rx_thr = `RX_THR_1;
				2'h2: rx_thr = `RX_THR_2;
				default: rx_thr = `RX_THR_3;
			endcase
		end
	endfunction

	function [LEVEL_W-1:0] tx_thr;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: tx_thr = `TX_THR_0;
				2'h1: tx_thr = `TX_THR_1;
				2'h2: tx_thr = `TX_THR_2;
				default: tx_thr = `TX_THR_3;
			endcase
		end
	endfunction

	function addr_hit;
		input [2:0] addr;
		input [2:0] ofs;
		begin
			addr_hit = (addr == ofs);
		end
	endfunction

	function lvl_empty;
		input [LEVEL_W-1:0] lvl;
		begin
			lvl_empty = (lvl == {LEVEL_W{1'b0}});
		end
	endfunction

	reg [7:0] int_en_ff;
	reg [7:0] fifo_ctrl_ff;
	reg [7:0] scratch_ff;
	reg line_event_ff;
	reg modem_event_ff;
	reg rx_timeout_flag_ff;
	reg tx_flag_ff;
	reg tx_low_prev_ff;

	reg [7:0] nxt_rdata;
	reg [3:0] legacy_code;
	reg [7:0] event_id;

	// Full decode, every offset mapped
	wire wr_data = reg_wr_in && addr_hit(reg_addr_in, `OFS_DATA_PORT);
	wire wr_int_en = reg_wr_in && addr_hit(reg_addr_in, `OFS_INT_EN);
	wire wr_fifo = reg_wr_in && addr_hit(reg_addr_in, `OFS_EVENT_FIFO);
	wire wr_line_ctrl = reg_wr_in && addr_hit(reg_addr_in, `OFS_LINE_CTRL);
	wire wr_modem_ctrl = reg_wr_in && addr_hit(reg_addr_in, `OFS_MODEM_CTRL);
	wire wr_scratch = reg_wr_in && addr_hit(reg_addr_in, `OFS_SCRATCH);
	wire rd_data = reg_rd_in && addr_hit(reg_addr_in, `OFS_DATA_PORT);
	wire rd_event = reg_rd_in && addr_hit(reg_addr_in, `OFS_EVENT_FIFO);
	wire rd_line = reg_rd_in && addr_hit(reg_addr_in, `OFS_LINE_STATUS);
	wire rd_modem = reg_rd_in && addr_hit(reg_addr_in, `OFS_MODEM_STATUS);

	wire fifo_en = fifo_ctrl_ff[`FC_FIFO_EN];
	wire ext = extended_select_in;
	wire [1:0] rx_sel = fifo_ctrl_ff[`FC_RX_THR_LSB+1:`FC_RX_THR_LSB];
	wire [1:0] tx_sel = fifo_ctrl_ff[`FC_TX_THR_LSB+1:`FC_TX_THR_LSB];

	// Holding register full, or fifo at or above threshold
	wire rx_level_cond = fifo_en ? (rx_level_in >= rx_thr(rx_sel)) : !lvl_empty(rx_level_in);
	// Timeout only means something while the receive fifo runs
	wire rx_timeout_cond = fifo_en && rx_timeout_flag_ff;
	// Thresholded transmit level exists only in extended mode
	wire tx_below_thr = fifo_en ? (tx_level_in < tx_thr(tx_sel)) : lvl_empty(tx_level_in);
	wire tx_low_legacy = lvl_empty(tx_level_in);
	wire tx_low_cond = ext ? tx_below_thr : tx_low_legacy;
	wire tx_empty_cond = tx_idle_in && lvl_empty(tx_level_in);

	// Enabled pending sources in legacy mode
	wire pend_line = line_event_ff && int_en_ff[`IE_LINE];
	wire pend_rx_level = rx_level_cond && int_en_ff[`IE_RX_LEVEL];
	wire pend_rx_to = rx_timeout_cond && int_en_ff[`IE_RX_LEVEL];
	wire pend_tx = tx_flag_ff && int_en_ff[`IE_TX_LEVEL];
	wire pend_modem = modem_event_ff && int_en_ff[`IE_MODEM];

	// Extended mode: plain level conditions, one enable each
	wire ext_rx = (rx_level_cond || rx_timeout_cond) && int_en_ff[`IE_RX_LEVEL];
	wire ext_tx = tx_low_cond && int_en_ff[`IE_TX_LEVEL];
	wire ext_empty = tx_empty_cond && int_en_ff[`IE_TX_EMPTY];

	wire any_legacy = pend_line || pend_rx_level || pend_rx_to || pend_tx || pend_modem;
	wire any_ext = ext_rx || ext_tx || pend_line || pend_modem || ext_empty;
	wire any_pending = ext ? any_ext : any_legacy;

	// Legacy priority encoder
	always @* begin
		if (pend_line) begin
			legacy_code = `CODE_LINE;
		end else if (pend_rx_level) begin
			legacy_code = `CODE_RX_LEVEL;
		end else if (pend_rx_to) begin
			legacy_code = `CODE_RX_TIMEOUT;
		end else if (pend_tx) begin
			legacy_code = `CODE_TX_LEVEL;
		end else if (pend_modem) begin
			legacy_code = `CODE_MODEM;
		end else begin
			legacy_code = `CODE_NONE;
		end
	end

	wire tx_is_highest = (legacy_code == `CODE_TX_LEVEL);

	// Event id as read by software
	always @* begin
		event_id = 8'h00;
		if (ext) begin
			event_id[`EV_RX_LEVEL] = rx_level_cond || rx_timeout_cond;
			event_id[`EV_TX_LEVEL] = tx_low_cond;
			event_id[`EV_LINE] = line_event_ff;
			event_id[`EV_MODEM] = modem_event_ff;
			event_id[`EV_TX_EMPTY] = tx_empty_cond;
		end else begin
			event_id[3:0] = legacy_code;
			event_id[7:6] = {fifo_en, fifo_en};
		end
	end

	// Read mux; unmapped bits read zero
	always @* begin
		nxt_rdata = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`OFS_DATA_PORT: nxt_rdata = rx_data_in;
				`OFS_INT_EN: nxt_rdata = ext ? int_en_ff : {4'h0, int_en_ff[3:0]};
				`OFS_EVENT_FIFO: nxt_rdata = event_id;
				`OFS_LINE_CTRL: nxt_rdata = line_ctrl_out;
				`OFS_MODEM_CTRL: nxt_rdata = modem_control_out;
				`OFS_LINE_STATUS: nxt_rdata = line_status_in;
				`OFS_MODEM_STATUS: nxt_rdata = modem_status_in;
				`OFS_SCRATCH: nxt_rdata = scratch_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// Read data stands one cycle only, zero otherwise
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			reg_rdata_out <= nxt_rdata;
		end
	end

	// Pop follows the read, so the next byte shows only after it was taken
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rx_pop_out <= 1'b0;
		end else begin
			rx_pop_out <= rd_data;
		end
	end

	// Enables; the upper nibble lives only while extended mode is selected
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			int_en_ff <= `RST_INT_EN;
		end else begin
			if (wr_int_en) begin
				int_en_ff[3:0] <= reg_wdata_in[3:0];
				if (ext) begin
					int_en_ff[`IE_EXT_MSB:`IE_EXT_LSB] <= reg_wdata_in[7:4];
				end
			end
			// Upper enables cannot outlive extended mode
			if (!ext) begin
				int_en_ff[`IE_EXT_MSB:`IE_EXT_LSB] <= 4'h0;
			end
		end
	end

	// Write only; reserved and self-clearing bits are not kept
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fifo_ctrl_ff <= `RST_FIFO_CTRL;
		end else begin
			if (wr_fifo) begin
				fifo_ctrl_ff <= {reg_wdata_in[7:4], 3'h0, reg_wdata_in[`FC_FIFO_EN]};
			end
		end
	end

	// Plain storage; no bank switching behind line control
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			line_ctrl_out <= `RST_BYTE;
			modem_control_out <= `RST_BYTE;
			scratch_ff <= `RST_BYTE;
		end else begin
			if (wr_line_ctrl) begin
				line_ctrl_out <= reg_wdata_in;
			end
			if (wr_modem_ctrl) begin
				modem_control_out <= reg_wdata_in;
			end
			if (wr_scratch) begin
				scratch_ff <= reg_wdata_in;
			end
		end
	end

	// Byte and push strobe toward the transmit path
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tx_data_out <= `RST_BYTE;
			tx_push_out <= 1'b0;
		end else begin
			tx_push_out <= wr_data;
			if (wr_data) begin
				tx_data_out <= reg_wdata_in;
			end
		end
	end

	// Soft resets and fifo enable toward both fifos
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rx_soft_reset_out <= 1'b0;
			tx_soft_reset_out <= 1'b0;
			fifos_on_out <= 1'b0;
		end else begin
			// Clearing the fifo enable also empties both fifos
			rx_soft_reset_out <= wr_fifo && (reg_wdata_in[`FC_RX_SRST] ||
				(fifo_en && !reg_wdata_in[`FC_FIFO_EN]));
			tx_soft_reset_out <= wr_fifo && (reg_wdata_in[`FC_TX_SRST] ||
				(fifo_en && !reg_wdata_in[`FC_FIFO_EN]));
			fifos_on_out <= wr_fifo ? reg_wdata_in[`FC_FIFO_EN] : fifo_en;
		end
	end

	// Sticky event flags; a new event wins over the clear
	// Line event clears on a line status read
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			line_event_ff <= 1'b0;
		end else begin
			if (line_error_in) begin
				line_event_ff <= 1'b1;
			end else if (rd_line) begin
				line_event_ff <= 1'b0;
			end
		end
	end

	// Modem event clears on a modem status read
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			modem_event_ff <= 1'b0;
		end else begin
			if (modem_change_in) begin
				modem_event_ff <= 1'b1;
			end else if (rd_modem) begin
				modem_event_ff <= 1'b0;
			end
		end
	end

	// Timeout clears only when the data port is read
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rx_timeout_flag_ff <= 1'b0;
		end else begin
			if (rx_timeout_in) begin
				rx_timeout_flag_ff <= 1'b1;
			end else if (rd_data) begin
				rx_timeout_flag_ff <= 1'b0;
			end
		end
	end

	// Edge set, so a serviced empty does not re-raise by itself
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tx_low_prev_ff <= 1'b0;
		end else begin
			tx_low_prev_ff <= tx_low_legacy;
		end
	end

	// Reset value 0 lets an empty fifo raise the flag right after reset
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tx_flag_ff <= 1'b0;
		end else begin
			if (tx_low_legacy && !tx_low_prev_ff) begin
				tx_flag_ff <= 1'b1;
			end else if (wr_data || (rd_event && !ext && tx_is_highest)) begin
				tx_flag_ff <= 1'b0;
			end
		end
	end

	// Registered so the pin carries no decode glitches
	always @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= any_pending;
		end
	end

endmodule // uart_bank0_host_registers

/* inc/uart_bank0_defs.vh */
`ifndef UART_BANK0_DEFS_VH
`define UART_BANK0_DEFS_VH

// Byte offsets of the bank 0 registers
`define OFS_DATA_PORT 3'h0
`define OFS_INT_EN 3'h1
`define OFS_EVENT_FIFO 3'h2
`define OFS_LINE_CTRL 3'h3
`define OFS_MODEM_CTRL 3'h4
`define OFS_LINE_STATUS 3'h5
`define OFS_MODEM_STATUS 3'h6
`define OFS_SCRATCH 3'h7

// Interrupt enable bit positions
`define IE_RX_LEVEL 0
`define IE_TX_LEVEL 1
`define IE_LINE 2
`define IE_MODEM 3
`define IE_TX_EMPTY 5
`define IE_EXT_MSB 7
`define IE_EXT_LSB 4

// Fifo control bit positions
`define FC_FIFO_EN 0
`define FC_RX_SRST 1
`define FC_TX_SRST 2
`define FC_TX_THR_LSB 4
`define FC_RX_THR_LSB 6

// Extended event id bit positions
`define EV_RX_LEVEL 0
`define EV_TX_LEVEL 1
`define EV_LINE 2
`define EV_MODEM 3
`define EV_TX_EMPTY 5

// Legacy event id codes, bits 3 to 0
`define CODE_NONE 4'h1
`define CODE_LINE 4'h6
`define CODE_RX_LEVEL 4'h4
`define CODE_RX_TIMEOUT 4'hC
`define CODE_TX_LEVEL 4'h2
`define CODE_MODEM 4'h0

// Threshold levels selected by the two-bit fields
`define RX_THR_0 5'h01
`define RX_THR_1 5'h04
`define RX_THR_2 5'h08
`define RX_THR_3 5'h0E
`define TX_THR_0 5'h01
`define TX_THR_1 5'h03
`define TX_THR_2 5'h09
`define TX_THR_3 5'h0D

// Reset values
`define RST_BYTE 8'h00
`define RST_INT_EN 8'h00
`define RST_FIFO_CTRL 8'h00

`endif

/* sim/uart_bank0_host_registers_assertions.sv */
`timescale 1ns/100ps
module uart_bank0_checker #(parameter LEVEL_W = 5) (
	input wire core_clk_in,
	input wire sys_rst_in,
	input wire [2:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_rdata_out,
	input wire extended_select_in,
	input wire [7:0] rx_data_in,
	input wire [7:0] line_status_in,
	input wire rx_pop_out,
	input wire rx_soft_reset_out,
	input wire [7:0] tx_data_out,
	input wire tx_push_out,
	input wire fifos_on_out,
	input wire irq_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (sys_rst_in);
wire rd_ev = reg_rd_in && reg_addr_in == 3'h2 && !extended_select_in;
a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
	else $error("read data not idle");
a_push_data: assert property (reg_wr_in && reg_addr_in == 3'h0 |=>
	tx_push_out && tx_data_out == $past(reg_wdata_in)) else $error("push wrong");
a_pop_data: assert property (reg_rd_in && reg_addr_in == 3'h0 |=>
	rx_pop_out && reg_rdata_out == $past(rx_data_in)) else $error("pop wrong");
a_ie_upper: assert property (reg_rd_in && reg_addr_in == 3'h1 && !extended_select_in
	|=> reg_rdata_out[7:4] == 4'h0) else $error("upper enables not zero");
a_fifo_mirror: assert property (rd_ev |=> reg_rdata_out[5:4] == 2'h0
	&& reg_rdata_out[7:6] == {2{$past(fifos_on_out)}}) else $error("fifo bits wrong");
a_timeout_bit: assert property (rd_ev && !fifos_on_out |=> !reg_rdata_out[3])
	else $error("timeout bit without fifo");
a_status_read: assert property (reg_rd_in && reg_addr_in == 3'h5 |=>
	reg_rdata_out == $past(line_status_in)) else $error("line status wrong");
a_soft_reset: assert property (reg_wr_in && reg_addr_in == 3'h2 && reg_wdata_in[1]
	|=> rx_soft_reset_out) else $error("no soft reset");
c_line_code: cover property (rd_ev ##1 reg_rdata_out[3:0] == 4'h6);
c_irq_rise: cover property ($rose(irq_out));
c_push: cover property (tx_push_out);
endmodule // uart_bank0_checker
bind uart_bank0_host_registers uart_bank0_checker #(.LEVEL_W(LEVEL_W)) u_chk (.*);

/* sim/uart_far_side.sv */
`timescale 1ns/100ps
module uart_far_side (
	input wire clk_in,
	input wire rst_in,
	input wire arrive_in,
	input wire rx_pop_in,
	input wire tx_push_in,
	output reg [7:0] rx_data_out,
	output reg [4:0] rx_level_out,
	output reg [4:0] tx_level_out,
	output wire tx_idle_out
);
reg [1:0] drain_ff;
assign tx_idle_out = tx_level_out == 5'h00;
always @(posedge clk_in or posedge rst_in) begin
	if (rst_in) begin
		rx_data_out <= 8'h5A;
		rx_level_out <= 5'h00;
		tx_level_out <= 5'h00;
		drain_ff <= 2'h0;
	end else begin
		// Byte moves on after a pop, so a stale read is caught
		if (rx_pop_in)
			rx_data_out <= rx_data_out + 8'h01;
		rx_level_out <= rx_level_out + {4'h0, arrive_in} - {4'h0, rx_pop_in && rx_level_out != 0};
		// Slow drain keeps the low-level edge apart from the push
		drain_ff <= tx_idle_out ? 2'h0 : drain_ff + 2'h1;
		tx_level_out <= tx_level_out + {4'h0, tx_push_in} - {4'h0, drain_ff == 2'h3};
	end
end
endmodule // uart_far_side

/* sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
reg core_clk_in = 1'b0;
reg sys_rst_in = 1'b1;
reg [2:0] reg_addr_in = 3'h0;
reg [7:0] reg_wdata_in = 8'h00;
reg reg_wr_in = 1'b0;
reg reg_rd_in = 1'b0;
reg extended_select_in = 1'b0;
reg rx_timeout_in = 1'b0;
reg line_error_in = 1'b0;
reg modem_change_in = 1'b0;
reg arrive = 1'b0;
reg [7:0] line_status_in = 8'h61;
reg [7:0] modem_status_in = 8'hB3;
wire [7:0] reg_rdata_out, rx_data_in, tx_data_out;
wire [4:0] rx_level_in, tx_level_in;
wire rx_pop_out, tx_push_out, tx_idle_in, irq_out, fifos_on;
reg [7:0] exp_q[$];
reg rd_seen = 1'b0;
reg [31:0] seed = 32'h8B8B;
reg [7:0] d;
integer num_errors = 0;
integer checks_done = 0;
integer i, j;
always #25 core_clk_in = ~core_clk_in;
uart_bank0_host_registers u_uart_bank0_host_registers (.*, .rx_soft_reset_out(),
	.tx_soft_reset_out(), .line_ctrl_out(), .modem_control_out(), .fifos_on_out(fifos_on));
uart_far_side u_uart_far_side (.clk_in(core_clk_in), .rst_in(sys_rst_in), .arrive_in(arrive),
	.rx_pop_in(rx_pop_out), .tx_push_in(tx_push_out), .rx_data_out(rx_data_in),
	.rx_level_out(rx_level_in), .tx_level_out(tx_level_in), .tx_idle_out(tx_idle_in));
function [31:0] rnd(input [31:0] s);
	rnd = s ^ (s << 13);
	rnd = rnd ^ (rnd >> 17);
	rnd = rnd ^ (rnd << 5);
endfunction
task summarize;
	begin
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
endtask
task check(input [7:0] seen, input [7:0] want);
	begin
		checks_done = checks_done + 1;
		if (seen !== want) begin
			num_errors = num_errors + 1;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	end
endtask
task bus(input w, input [2:0] a, input [7:0] v);
	begin
		@(posedge core_clk_in);
		reg_wr_in <= w;
		reg_rd_in <= !w;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		if (!w)
			exp_q.push_back(v);
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
	end
endtask
// Event pulse: 0 arrival, 1 modem, 2 line, 3 timeout
task pulse(input [1:0] k);
	begin
		@(posedge core_clk_in);
		{rx_timeout_in, line_error_in, modem_change_in, arrive} <= 4'h1 << k;
		@(posedge core_clk_in);
		{rx_timeout_in, line_error_in, modem_change_in, arrive} <= 4'h0;
		repeat (2) @(posedge core_clk_in);
	end
endtask
task wait_irq(input v);
	begin
		for (i = 0; i < 20 && irq_out !== v; i = i + 1)
			@(posedge core_clk_in);
		check({7'h0, irq_out}, {7'h0, v});
		if (i == 20)
			summarize;
	end
endtask
always @(posedge core_clk_in) begin
	if (rd_seen)
		check(reg_rdata_out, exp_q.pop_front());
	rd_seen <= reg_rd_in;
end
initial begin
	repeat (5000) @(posedge core_clk_in);
	num_errors = num_errors + 1;
	summarize;
end
initial begin
	repeat (3) @(posedge core_clk_in);
	sys_rst_in <= 1'b0;
	check({7'h0, fifos_on}, 8'h00);
	bus(0, 3'h0, 8'h5A);
	for (j = 1; j < 8; j = j + 1)
		bus(0, j, j == 2 ? 8'h01 : j == 5 ? 8'h61 : j == 6 ? 8'hB3 : 8'h00);
	for (j = 3; j < 8; j = j + 1) begin
		seed = rnd(seed);
		d = seed[7:0];
		bus(1, j, d);
		bus(0, j, j == 5 ? 8'h61 : j == 6 ? 8'hB3 : d);
	end
	bus(1, 3'h1, 8'hFF);
	bus(0, 3'h1, 8'h0F);
	extended_select_in <= 1'b1;
	bus(1, 3'h1, 8'h2F);
	bus(0, 3'h1, 8'h2F);
	extended_select_in <= 1'b0;
	bus(0, 3'h1, 8'h0F);
	pulse(1);
	pulse(2);
	pulse(0);
	wait_irq(1'b1);
	bus(0, 3'h2, 8'h06);
	bus(0, 3'h5, 8'h61);
	bus(0, 3'h2, 8'h04);
	bus(0, 3'h0, 8'h5B);
	repeat (2) @(posedge core_clk_in);
	bus(0, 3'h2, 8'h02);
	bus(0, 3'h2, 8'h00);
	bus(0, 3'h6, 8'hB3);
	bus(0, 3'h2, 8'h01);
	wait_irq(1'b0);
	// Enables off while polling, as software should
	bus(1, 3'h1, 8'h00);
	pulse(2);
	bus(0, 3'h2, 8'h01);
	check({7'h0, irq_out}, 8'h00);
	bus(0, 3'h5, 8'h61);
	bus(1, 3'h1, 8'h02);
	seed = rnd(seed);
	d = seed[7:0];
	bus(1, 3'h0, d);
	#1 check(tx_data_out, d);
	wait_irq(1'b1);
	bus(0, 3'h2, 8'h02);
	bus(1, 3'h2, 8'h03);
	#1 check({7'h0, fifos_on}, 8'h01);
	bus(1, 3'h1, 8'h01);
	pulse(3);
	bus(0, 3'h2, 8'hCC);
	bus(0, 3'h0, 8'h5C);
	bus(0, 3'h2, 8'hC1);
	extended_select_in <= 1'b1;
	bus(0, 3'h2, 8'h22);
	repeat (2) @(posedge core_clk_in);
	summarize;
end
endmodule // tb_top
